//--- hw/bsf_exec.sv
// Executes bit, stack, shift and flag instructions of an 8-bit core
`timescale 1ns/1ps
module bsf_exec (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic instr_valid,
    input wire bsf_pkg::bsf_instr_t instr,
    output logic instr_ready,
    output logic done,
    output logic [7:0] status_flags_register,
    output logic [7:0] stack_ptr,
    output logic sleep_req,
    output logic watchdog_restart_op,
    output logic break_req,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic [bsf_pkg::REG_AW-1:0] reg_addr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] io_port
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_POP_WR} bsf_state_t;

    bsf_state_t state_r;
    bsf_state_t state_nxt;
    logic [7:0] regs_r [0:(1 << bsf_pkg::REG_AW)-1];
    logic [7:0] io_r [0:(1 << bsf_pkg::IO_AW)-1];
    logic [7:0] flags_r;
    logic [7:0] sp_r;
    logic [1:0] wait_r;
    logic [bsf_pkg::REG_AW-1:0] pop_dst_r;
    logic pop_sram_r;
    logic [7:0] rdata_r;
    logic done_r;
    logic sleep_r;
    logic wdog_r;
    logic brk_r;

    // =====================================
    // Decode
    wire take = ce && instr_valid && instr_ready;
    wire [7:0] src_val = regs_r[instr.reg_sel];
    wire [7:0] bit_mask = 8'h01 << instr.bit_sel;
    wire is_shift = instr.op inside {bsf_pkg::OP_SHIFT_LEFT_LOGICAL, bsf_pkg::OP_SHIFT_RIGHT_LOGICAL,
        bsf_pkg::OP_ROTATE_LEFT_CARRY, bsf_pkg::OP_ROTATE_RIGHT_CARRY,
        bsf_pkg::OP_SHIFT_RIGHT_ARITHMETIC, bsf_pkg::OP_SWAP};
    wire is_push = instr.op == bsf_pkg::OP_PUSH;
    wire is_pop = instr.op == bsf_pkg::OP_POP;
    wire [7:0] sp_dec = sp_r - 8'h01;
    wire [7:0] sp_inc = sp_r + 8'h01;
    wire [7:0] stack_rd;
    bsf_pkg::bsf_alu_t alu;

    assign instr_ready = (state_r == ST_IDLE);
    assign done = done_r;
    assign status_flags_register = flags_r;
    assign stack_ptr = sp_r;
    assign sleep_req = sleep_r;
    assign watchdog_restart_op = wdog_r;
    assign break_req = brk_r;
    assign reg_rdata = rdata_r;
    assign io_port = io_r[0];

    bsf_shift_unit u_shift (
        .op(instr.op),
        .operand(src_val),
        .flags_in(flags_r),
        .result(alu)
    );

    // Push stores at SP then post-decrements; pop pre-increments
    bsf_stack_ram u_stack (
        .clk_sys(clk_sys),
        .ce(ce),
        .wr_en(take && is_push),
        .wr_addr(sp_r),
        .wr_data(src_val),
        .rd_addr(sp_inc),
        .rd_data(stack_rd)
    );

    // =====================================
    // Sequencer: push one cycle, pop two, plus one for SRAM
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take && is_pop) begin
                    state_nxt = ST_POP_WR;
                end else if (take && is_push && instr.sram_mode) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_POP_WR: begin
                state_nxt = pop_sram_r ? ST_WAIT : ST_IDLE;
            end
            ST_WAIT: begin
                if (wait_r == 2'h1) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // =====================================
    // Control state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            wait_r <= 2'h0;
            pop_dst_r <= '0;
            pop_sram_r <= 1'b0;
            done_r <= 1'b0;
            sleep_r <= 1'b0;
            wdog_r <= 1'b0;
            brk_r <= 1'b0;
            sp_r <= bsf_pkg::SP_RST;
            rdata_r <= bsf_pkg::REG_RST;
        end else if (ce) begin
            state_r <= state_nxt;
            wait_r <= (state_nxt == ST_WAIT && state_r != ST_WAIT) ? bsf_pkg::SRAM_EXTRA_CYC :
                (wait_r != 2'h0 ? wait_r - 2'h1 : 2'h0);
            done_r <= (take && !is_pop && !(is_push && instr.sram_mode)) ||
                (state_r == ST_POP_WR && !pop_sram_r) || (state_r == ST_WAIT && wait_r == 2'h1);
            sleep_r <= take && instr.op == bsf_pkg::OP_SLEEP;
            wdog_r <= take && instr.op == bsf_pkg::OP_WATCHDOG_RESTART;
            brk_r <= take && instr.op == bsf_pkg::OP_BREAK;
            rdata_r <= reg_rd ? regs_r[reg_addr] : rdata_r;
            if (take && is_pop) begin
                pop_dst_r <= instr.reg_sel;
                pop_sram_r <= instr.sram_mode;
                sp_r <= sp_inc;
            end else if (take && is_push) begin
                sp_r <= sp_dec;
            end
        end
    end

    // =====================================
    // Status register: only named flags change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= bsf_pkg::STATUS_RST;
        end else if (ce && take) begin
            case (instr.op)
                bsf_pkg::OP_FLAG_SET: flags_r <= flags_r | bit_mask;
                bsf_pkg::OP_FLAG_CLEAR: flags_r <= flags_r & ~bit_mask;
                bsf_pkg::OP_STORE_BIT: flags_r[bsf_pkg::FLAG_T] <= |(src_val & bit_mask);
                default: flags_r <= alu.flags;
            endcase
        end
    end

    // =====================================
    // Register file and I/O registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < (1 << bsf_pkg::REG_AW); i++) begin
                regs_r[i] <= bsf_pkg::REG_RST;
                io_r[i] <= bsf_pkg::REG_RST;
            end
        end else if (ce) begin
            if (reg_we) begin
                regs_r[reg_addr] <= reg_wdata;
            end
            if (state_r == ST_POP_WR) begin
                regs_r[pop_dst_r] <= stack_rd;
            end else if (take && is_shift) begin
                regs_r[instr.reg_sel] <= alu.value;
            end else if (take && instr.op == bsf_pkg::OP_LOAD_BIT) begin
                regs_r[instr.reg_sel][instr.bit_sel] <= flags_r[bsf_pkg::FLAG_T];
            end
            if (take && instr.op == bsf_pkg::OP_SET_IO_BIT) begin
                io_r[instr.io_addr] <= io_r[instr.io_addr] | bit_mask;
            end else if (take && instr.op == bsf_pkg::OP_CLEAR_IO_BIT) begin
                io_r[instr.io_addr] <= io_r[instr.io_addr] & ~bit_mask;
            end
        end
    end
    // Counts add SRAM_EXTRA_CYC wait cycles in sram_mode; data still comes from internal stack RAM
endmodule

//--- hw/bsf_pkg.sv
// Package of constants and types for the bit, stack and flag instruction slice
package bsf_pkg;

    // =====================================
    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // =====================================
    // Reset values and cycle counts
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] SP_RST = 8'hff;
    localparam logic [1:0] PUSH_CYC = 2'h1;
    localparam logic [1:0] POP_CYC = 2'h2;
    localparam logic [1:0] SRAM_EXTRA_CYC = 2'h1;
    localparam int REG_AW = 5;
    localparam int IO_AW = 5;
    localparam int STACK_AW = 8;

    // =====================================
    // Operations
    typedef enum logic [4:0] {
        OP_NOP, OP_PUSH, OP_POP, OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITHMETIC,
        OP_SWAP, OP_FLAG_SET, OP_FLAG_CLEAR, OP_SET_IO_BIT, OP_CLEAR_IO_BIT,
        OP_STORE_BIT, OP_LOAD_BIT, OP_SLEEP, OP_WATCHDOG_RESTART, OP_BREAK
    } bsf_op_t;

    // Instruction word offered to the slice
    typedef struct packed {
        bsf_op_t op;
        logic [REG_AW-1:0] reg_sel;
        logic [IO_AW-1:0] io_addr;
        logic [2:0] bit_sel;
        logic sram_mode;
    } bsf_instr_t;

    typedef struct packed {
        logic [7:0] value;
        logic [7:0] flags;
    } bsf_alu_t;

endpackage

//--- hw/bsf_shift_unit.sv
// Shift, rotate and swap datapath with flag results
`timescale 1ns/1ps
module bsf_shift_unit (
    input wire bsf_pkg::bsf_op_t op,
    input wire logic [7:0] operand,
    input wire logic [7:0] flags_in,
    output bsf_pkg::bsf_alu_t result
);
    logic [7:0] res;
    logic cout;
    logic half;
    logic upd_h;
    logic upd_flags;

    // =====================================
    // Result selection
    always_comb begin
        res = operand;
        cout = flags_in[bsf_pkg::FLAG_C];
        half = flags_in[bsf_pkg::FLAG_H];
        upd_h = 1'b0;
        upd_flags = 1'b1;
        case (op)
            bsf_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                res = {operand[6:0], 1'b0};
                cout = operand[7];
                half = operand[3];
                upd_h = 1'b1;
            end
            bsf_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
                res = {1'b0, operand[7:1]};
                cout = operand[0];
            end
            bsf_pkg::OP_ROTATE_LEFT_CARRY: begin
                res = {operand[6:0], flags_in[bsf_pkg::FLAG_C]};
                cout = operand[7];
                half = operand[3];
                upd_h = 1'b1;
            end
            bsf_pkg::OP_ROTATE_RIGHT_CARRY: begin
                res = {flags_in[bsf_pkg::FLAG_C], operand[7:1]};
                cout = operand[0];
            end
            bsf_pkg::OP_SHIFT_RIGHT_ARITHMETIC: begin
                res = {operand[7], operand[7:1]};
                cout = operand[0];
            end
            bsf_pkg::OP_SWAP: begin
                res = {operand[3:0], operand[7:4]};
                upd_flags = 1'b0;
            end
            default: begin
                upd_flags = 1'b0;
            end
        endcase
    end

    // =====================================
    // Flag update: V = N xor C, S = N xor V
    logic n_f;
    logic v_f;
    assign n_f = res[7];
    assign v_f = n_f ^ cout;

    always_comb begin
        result.value = res;
        result.flags = flags_in;
        if (upd_flags) begin
            result.flags[bsf_pkg::FLAG_C] = cout;
            result.flags[bsf_pkg::FLAG_Z] = (res == 8'h00);
            result.flags[bsf_pkg::FLAG_N] = n_f;
            result.flags[bsf_pkg::FLAG_V] = v_f;
            result.flags[bsf_pkg::FLAG_S] = n_f ^ v_f;
            if (upd_h) begin
                result.flags[bsf_pkg::FLAG_H] = half;
            end
        end
    end
endmodule

//--- hw/bsf_stack_ram.sv
// Internal stack memory, one write and one registered read port
`timescale 1ns/1ps
module bsf_stack_ram (
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [bsf_pkg::STACK_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [bsf_pkg::STACK_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:(1 << bsf_pkg::STACK_AW)-1];

    // =====================================
    // Synchronous write and read
    always_ff @(posedge clk_sys) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

//--- testbench/bsf_exec_chk.sv
// Concurrent checks on the ports of the instruction slice
`timescale 1ns/1ps
module bsf_exec_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic instr_valid,
    input wire bsf_pkg::bsf_instr_t instr,
    input wire logic instr_ready,
    input wire logic done,
    input wire logic [7:0] status_flags_register,
    input wire logic [7:0] stack_ptr,
    input wire logic [7:0] io_port,
    input wire logic sleep_req,
    input wire logic watchdog_restart_op,
    input wire logic break_req
);
    // ====
    // Take decode
    wire tk = ce && instr_valid && instr_ready;
    wire [7:0] bm = 8'h01 << instr.bit_sel;
    wire [2:0] ctl_tk = {tk && instr.op == bsf_pkg::OP_SLEEP, tk && instr.op == bsf_pkg::OP_WATCHDOG_RESTART,
        tk && instr.op == bsf_pkg::OP_BREAK};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // ====
    // Properties
    a_push_one: assert property (tk && instr.op == bsf_pkg::OP_PUSH && !instr.sram_mode |->
        ##1 done && stack_ptr == $past(stack_ptr) - 8'h01) else $error("push timing or pointer wrong");
    a_pop_two: assert property (tk && instr.op == bsf_pkg::OP_POP && !instr.sram_mode |->
        ##1 !done && !instr_ready ##1 done) else $error("pop timing wrong");
    a_pop_flags: assert property (tk && instr.op == bsf_pkg::OP_POP |->
        ##1 $stable(status_flags_register) [*2]) else $error("pop changed flags");
    a_sram_extra: assert property (tk && instr.op == bsf_pkg::OP_POP && instr.sram_mode |->
        ##1 !done [*2] ##1 done) else $error("extra memory cycle missing");
    a_flag_set: assert property (tk && instr.op == bsf_pkg::OP_FLAG_SET |->
        ##1 status_flags_register == ($past(status_flags_register) | $past(bm))) else $error("flag set wrong");
    a_flag_clear: assert property (tk && instr.op == bsf_pkg::OP_FLAG_CLEAR |->
        ##1 status_flags_register == ($past(status_flags_register) & ~$past(bm))) else $error("flag clear wrong");
    a_io_set: assert property (tk && instr.op == bsf_pkg::OP_SET_IO_BIT && instr.io_addr == 5'h00 |->
        ##1 io_port == ($past(io_port) | $past(bm)) && $stable(status_flags_register)) else $error("io set wrong");
    a_io_clear: assert property (tk && instr.op == bsf_pkg::OP_CLEAR_IO_BIT && instr.io_addr == 5'h00 |->
        ##1 io_port == ($past(io_port) & ~$past(bm)) && $stable(status_flags_register)) else $error("io clear wrong");
    a_swap_flags: assert property (tk && instr.op == bsf_pkg::OP_SWAP |->
        ##1 done && $stable(status_flags_register)) else $error("swap changed flags");
    a_ce_freeze: assert property (!ce |=> $stable(status_flags_register) && $stable(stack_ptr) &&
        $stable(io_port) && $stable(done)) else $error("state moved with clock enable low");
    a_ctrl_pulse: assert property (ce |=>
        {sleep_req, watchdog_restart_op, break_req} == $past(ctl_tk)) else $error("control pulse wrong");
endmodule

bind bsf_exec bsf_exec_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .done(done), .status_flags_register(status_flags_register),
    .stack_ptr(stack_ptr), .io_port(io_port), .sleep_req(sleep_req), .watchdog_restart_op(watchdog_restart_op),
    .break_req(break_req));

//--- testbench/bsf_exec_tb_top.sv
// Self-checking bench for the instruction slice
`timescale 1ns/1ps
module bsf_exec_tb_top;
    // ====
    // Signals and model state
    logic clk_sys, rst_b, ce, instr_valid, reg_we, reg_rd, rd_d, instr_ready, done;
    bsf_pkg::bsf_instr_t instr;
    logic [7:0] reg_wdata, reg_rdata, status_flags_register, stack_ptr, io_port, f, io, sp, rnd;
    logic [7:0] rf [32];
    logic [4:0] reg_addr;
    logic [7:0] q_rd [$];
    logic [7:0] stk [$];
    logic [15:0] q_done [$];
    int errors, tests_run, i;
    wire [15:0] seen_st = {io_port, status_flags_register};

    bsf_exec uut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .done(done), .status_flags_register(status_flags_register),
        .stack_ptr(stack_ptr), .sleep_req(), .watchdog_restart_op(), .break_req(), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_port(io_port));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ====
    // Helpers
    function automatic logic [7:0] lfsr(logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    function automatic logic [15:0] alu(bsf_pkg::bsf_op_t op, logic [7:0] v, logic [7:0] g);
        logic [7:0] r;
        logic c;
        c = v[0];
        case (op)
            bsf_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                r = {v[6:0], 1'b0};
                c = v[7];
                g[5] = v[3];
            end
            bsf_pkg::OP_ROTATE_LEFT_CARRY: begin
                r = {v[6:0], g[0]};
                c = v[7];
                g[5] = v[3];
            end
            bsf_pkg::OP_SHIFT_RIGHT_LOGICAL: r = {1'b0, v[7:1]};
            bsf_pkg::OP_ROTATE_RIGHT_CARRY: r = {g[0], v[7:1]};
            bsf_pkg::OP_SHIFT_RIGHT_ARITHMETIC: r = {v[7], v[7:1]};
            bsf_pkg::OP_SWAP: return {v[3:0], v[7:4], g};
            default: return {v, g};
        endcase
        g[2:0] = {r[7], r == 8'h00, c};
        g[3] = r[7] ^ c;
        g[4] = g[2] ^ g[3];
        return {r, g};
    endfunction

    task automatic check(logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(logic [4:0] a, logic [7:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        rf[a] = d;
        @(posedge clk_sys);
        reg_we <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(logic [4:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        q_rd.push_back(rf[a]);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic ex(bsf_pkg::bsf_op_t op, logic [4:0] r, logic [2:0] b, logic [4:0] a = 5'h00, logic s = 1'b0);
        int n;
        int cy;
        cy = 1;
        case (op)
            bsf_pkg::OP_FLAG_SET: f[b] = 1'b1;
            bsf_pkg::OP_FLAG_CLEAR: f[b] = 1'b0;
            bsf_pkg::OP_STORE_BIT: f[6] = rf[r][b];
            bsf_pkg::OP_LOAD_BIT: rf[r][b] = f[6];
            bsf_pkg::OP_SET_IO_BIT: if (a == 5'h00) io[b] = 1'b1;
            bsf_pkg::OP_CLEAR_IO_BIT: if (a == 5'h00) io[b] = 1'b0;
            bsf_pkg::OP_PUSH: begin
                stk.push_back(rf[r]);
                sp--;
                cy = bsf_pkg::PUSH_CYC + (s ? bsf_pkg::SRAM_EXTRA_CYC : 2'h0);
            end
            bsf_pkg::OP_POP: begin
                rf[r] = stk.pop_back();
                sp++;
                cy = bsf_pkg::POP_CYC + (s ? bsf_pkg::SRAM_EXTRA_CYC : 2'h0);
            end
            default: {rf[r], f} = alu(op, rf[r], f);
        endcase
        q_done.push_back({io, f});
        instr_valid <= 1'b1;
        instr <= '{op, r, a, b, s};
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (done !== 1'b1 && n < 8);
        check(16'(n), 16'(cy));
        check({8'h00, stack_ptr}, {8'h00, sp});
        @(posedge clk_sys);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ====
    // Result monitor
    always @(posedge clk_sys) rd_d <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_d === 1'b1) begin
            check(16'(reg_rdata), 16'(q_rd.pop_front()));
        end
        if (done === 1'b1) begin
            check(seen_st, q_done.pop_front());
        end
    end

    initial begin
        #200000;
        errors++;
        wrap_up;
    end

    // ====
    // Main sequence
    initial begin
        {rst_b, instr_valid, reg_we, reg_rd} = 4'h0;
        ce = 1'b1;
        instr = '0;
        reg_wdata = 8'h00;
        reg_addr = 5'h00;
        errors = 0;
        tests_run = 0;
        rnd = 8'h4b;
        {f, sp, io} = {bsf_pkg::STATUS_RST, bsf_pkg::SP_RST, 8'h00};
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        check({stack_ptr, status_flags_register}, {bsf_pkg::SP_RST, bsf_pkg::STATUS_RST});
        for (i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            wr(5'(i), rnd);
        end
        for (i = 0; i < 16; i++) ex(i < 8 ? bsf_pkg::OP_FLAG_SET : bsf_pkg::OP_FLAG_CLEAR, 0, 3'(i * 3));
        $display("test flags finished");
        for (i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            ex(rnd[0] ? bsf_pkg::OP_FLAG_SET : bsf_pkg::OP_FLAG_CLEAR, 0, 0);
            ex(bsf_pkg::bsf_op_t'(3 + i % 6), 5'(i), 0);
        end
        $display("test shifts finished");
        for (i = 0; i < 8; i++) begin
            ex(bsf_pkg::OP_STORE_BIT, 5'(i), 3'(i));
            ex(bsf_pkg::OP_LOAD_BIT, 5'(31 - i), 3'(7 - i));
        end
        for (i = 0; i < 16; i++) begin
            ex(i < 8 ? bsf_pkg::OP_SET_IO_BIT : bsf_pkg::OP_CLEAR_IO_BIT, 0, 3'(i * 3), 5'(i % 3));
        end
        for (i = 15; i < 18; i++) ex(bsf_pkg::bsf_op_t'(i), 0, 0);
        ex(bsf_pkg::OP_NOP, 0, 0);
        $display("test bit and io finished");
        ce <= 1'b0;
        instr_valid <= 1'b1;
        instr <= '{bsf_pkg::OP_PUSH, 5'h01, 5'h00, 3'h0, 1'b0};
        repeat (3) @(posedge clk_sys);
        {ce, instr_valid} <= 2'b10;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check({8'h00, stack_ptr}, {8'h00, sp});
        check(seen_st, {io, f});
        @(posedge clk_sys);
        $display("test clock enable finished");
        for (i = 0; i < 6; i++) ex(bsf_pkg::OP_PUSH, 5'(i), 0, 0, i[0]);
        for (i = 0; i < 6; i++) ex(bsf_pkg::OP_POP, 5'(i + 10), 0, 0, i[1]);
        $display("test stack finished");
        for (i = 0; i < 32; i++) rd(5'(i));
        $display("test readback finished");
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        {f, sp, io} = {bsf_pkg::STATUS_RST, bsf_pkg::SP_RST, 8'h00};
        @(posedge clk_sys);
        check(seen_st, {8'h00, bsf_pkg::STATUS_RST});
        check({8'h00, stack_ptr}, {8'h00, bsf_pkg::SP_RST});
        ex(bsf_pkg::OP_PUSH, 5'h00, 3'h0);
        ex(bsf_pkg::OP_FLAG_SET, 5'h00, 3'h7);
        $display("test reset finished");
        repeat (2) @(posedge clk_sys);
        wrap_up;
    end
endmodule
